// *** rtl/jdb_control.sv ***
// Jog and external DC-brake terminal control.
// Contract
// - Jog frequency command is capped at 10 Hz.
// - Jog drives the jog frequency directly, no acceleration ramp.
// - Modes 0 to 2 ignore jog while running; 3 to 5 accept it.
// - Jog ends by coast, normal decel, or DC brake per mode.
// - Enabled modes: jog interrupts a normal run.
// - Jog asserted before run terminal starts the jog.
// - Terminal coded 06 is the jog request.
// - No jog if jog frequency zero, below start, or mode above 5.
// - Terminal coded 07 enables DC braking while asserted; the code ignores it in ST_JOG and ST_LOCKOUT.
// - Brake delay programmable 0.0 to 5.0 seconds.
// - Brake force programmable 0 to 100 percent.
// - Terminal run: brake release ramps back to previous frequency.
// - Keypad run: brake applies, output stays off after release.
// - With a delay, coast first, brake once delay expires.
`timescale 1ns/1ps
`include "jdb_defines.svh"

module jdb_control (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_reset,
	// Terminals, asynchronous to the clock.
	input wire logic i_term_a,
	input wire logic i_term_b,
	input wire logic i_forward_run_input,
	input wire logic i_reverse_run_input,
	// Keypad run command and motor stopped indication, same clock.
	input wire logic i_keypad_run,
	input wire logic i_motor_stopped,
	// Configuration.
	input wire logic [7:0] i_term_a_func,
	input wire logic [7:0] i_term_b_func,
	input wire logic [1:0] i_run_source_param,
	input wire logic [2:0] i_jog_mode_param,
	input wire logic [15:0] i_jog_frequency_param,
	input wire logic [15:0] i_start_frequency_param,
	input wire logic [15:0] i_set_frequency,
	input wire logic [5:0] i_brake_delay_param,
	input wire logic [6:0] i_brake_force_param,
	// Drive command outputs.
	output logic [1:0] o_drive_mode,
	output logic [15:0] o_freq_cmd,
	output logic [6:0] o_brake_force,
	output logic o_jogging,
	output logic o_config_error
);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [15:0] jdb_min16(input logic [15:0] a, input logic [15:0] b);
		jdb_min16 = (a < b) ? a : b;
	endfunction : jdb_min16

	// A function code placed on both terminals acts on either of them.
	function automatic logic term_is(input logic [7:0] func_a, input logic lvl_a,
		input logic [7:0] func_b, input logic lvl_b, input logic [7:0] code);
		term_is = ((func_a == code) && lvl_a) || ((func_b == code) && lvl_b);
	endfunction : term_is

	// ----------------------------------------
	// Synchronisers
	// ----------------------------------------
	logic [3:0] sync1;
	logic [3:0] sync2;
	// Only the second stage feeds logic; a terminal change acts three edges after it.
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			sync1 <= 4'h0;
			sync2 <= 4'h0;
		end else begin
			sync1 <= {i_reverse_run_input, i_forward_run_input, i_term_b, i_term_a};
			sync2 <= sync1;
		end
	end

	logic jog_request;
	logic dc_brake_request;
	logic run_term;
	logic terminal_src;
	logic run_cmd;
	assign jog_request = term_is(i_term_a_func, sync2[0], i_term_b_func, sync2[1], `JDB_FUNC_JOG);
	assign dc_brake_request = term_is(i_term_a_func, sync2[0], i_term_b_func, sync2[1], `JDB_FUNC_BRAKE);
	assign run_term = sync2[2] | sync2[3];
	assign terminal_src = (i_run_source_param == `JDB_SRC_TERMINAL);
	assign run_cmd = terminal_src ? run_term : i_keypad_run;

	// ----------------------------------------
	// Configuration checks
	// ----------------------------------------
	logic mode_valid;
	logic jog_allowed;
	logic jog_in_run;
	logic [15:0] jog_freq;
	logic [5:0] delay_clamped;
	logic [6:0] force_clamped;
	// Codes above five fail the validity test, so they can never start a jog.
	assign mode_valid = (i_jog_mode_param <= `JDB_MODE_MAX);
	assign jog_allowed = mode_valid && (i_jog_frequency_param != `JDB_FREQ_ZERO)
		&& (i_jog_frequency_param >= i_start_frequency_param);
	assign jog_in_run = (i_jog_mode_param >= `JDB_MODE_COAST_EN);
	assign jog_freq = jdb_min16(i_jog_frequency_param, `JDB_JOG_CAP);
	// Out-of-range settings are clamped rather than rejected so the brake stays usable.
	assign delay_clamped = (i_brake_delay_param > `JDB_DELAY_MAX) ? `JDB_DELAY_MAX : i_brake_delay_param;
	assign force_clamped = (i_brake_force_param > `JDB_FORCE_MAX) ? `JDB_FORCE_MAX : i_brake_force_param;

	// ----------------------------------------
	// Tenth-second tick
	// ----------------------------------------
	logic [21:0] tick_cnt;
	logic [21:0] next_tick_cnt;
	logic tick;
	// The tick runs free, so the first tenth of a brake delay may be short by up to one tenth.
	assign tick = (tick_cnt == 22'(`JDB_TENTH_CYCLES - 1));
	always_comb begin
		next_tick_cnt = tick ? 22'h000000 : tick_cnt + 22'h000001;
	end
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			tick_cnt <= 22'h000000;
		end else begin
			tick_cnt <= next_tick_cnt;
		end
	end

	// ----------------------------------------
	// Control state machine
	// ----------------------------------------
	jdb_pkg::jdb_state_e state;
	jdb_pkg::jdb_state_e next_state;
	// A run that arrives while jog is held starts a jog; a run already held does not.
	logic run_prev;
	logic [5:0] delay_cnt;
	logic [5:0] next_delay_cnt;
	logic [15:0] saved_freq;
	logic [15:0] next_saved_freq;
	logic [1:0] next_drive_mode;
	logic [15:0] next_freq_cmd;
	logic [6:0] next_brake_force;
	logic next_jogging;
	logic next_config_error;
	// Set when a jog ends in DC braking: the brake then holds until standstill, not until the terminal drops.
	logic jog_stop;
	logic next_jog_stop;

	always_comb begin
		next_state = state;
		next_jog_stop = jog_stop;
		next_delay_cnt = delay_cnt;
		next_saved_freq = saved_freq;
		case (state)
			jdb_pkg::ST_IDLE: begin
				if (dc_brake_request) begin
					next_delay_cnt = delay_clamped;
					next_state = jdb_pkg::ST_BRAKE_WAIT;
				end else if (run_cmd && jog_request && !run_prev) begin
					// Jog was already on when run arrived.
					// A refused jog locks the output off until run and jog are both withdrawn.
					if (jog_allowed) begin
						next_state = jdb_pkg::ST_JOG;
					end else begin
						next_state = jdb_pkg::ST_LOCKOUT;
					end
				end else if (run_cmd && !jog_request) begin
					next_state = jdb_pkg::ST_RUN;
				end
			end
			jdb_pkg::ST_RUN: begin
				// The set frequency is held here so a brake release can ramp back to it.
				next_saved_freq = i_set_frequency;
				if (dc_brake_request) begin
					next_delay_cnt = delay_clamped;
					next_state = jdb_pkg::ST_BRAKE_WAIT;
				end else if (!run_cmd) begin
					next_state = jdb_pkg::ST_DECEL;
				end else if (jog_request && jog_in_run && jog_allowed) begin
					next_state = jdb_pkg::ST_JOG;
				end
			end
			jdb_pkg::ST_JOG: begin
				// Dropping the run command ends a jog the same way as releasing the jog terminal.
				if (!jog_request || !run_cmd) begin
					case (i_jog_mode_param)
						`JDB_MODE_COAST_DIS, `JDB_MODE_COAST_EN: next_state = jdb_pkg::ST_COAST;
						`JDB_MODE_DECEL_DIS, `JDB_MODE_DECEL_EN: next_state = jdb_pkg::ST_DECEL;
						default: begin
							next_delay_cnt = `JDB_DELAY_ZERO;
							next_jog_stop = 1'b1;
							next_state = jdb_pkg::ST_BRAKE;
						end
					endcase
				end
			end
			jdb_pkg::ST_COAST, jdb_pkg::ST_DECEL: begin
				// A brake request during a stop starts the brake delay afresh.
				if (dc_brake_request) begin
					next_delay_cnt = delay_clamped;
					next_state = jdb_pkg::ST_BRAKE_WAIT;
				end else if (i_motor_stopped) begin
					next_state = jdb_pkg::ST_IDLE;
				end
			end
			jdb_pkg::ST_BRAKE_WAIT: begin
				// The motor coasts while the delay runs; an early release skips the brake.
				if (!dc_brake_request) begin
					next_state = (terminal_src && run_term) ? jdb_pkg::ST_RUN : jdb_pkg::ST_LOCKOUT;
				end else if (delay_cnt == `JDB_DELAY_ZERO) begin
					next_state = jdb_pkg::ST_BRAKE;
				end else if (tick) begin
					next_delay_cnt = delay_cnt - 6'h01;
				end
			end
			jdb_pkg::ST_BRAKE: begin
				if (jog_stop) begin
					// A jog stopped by DC braking keeps braking until the shaft is still.
					if (i_motor_stopped) begin
						next_jog_stop = 1'b0;
						next_state = jdb_pkg::ST_IDLE;
					end
				end else if (!dc_brake_request && !jog_request) begin
					next_state = (terminal_src && run_term) ? jdb_pkg::ST_RUN : jdb_pkg::ST_LOCKOUT;
				end
			end
			jdb_pkg::ST_LOCKOUT: begin
				// Output stays off until the selected run command and the jog request are both withdrawn.
				if (!run_cmd && !jog_request) begin
					next_state = jdb_pkg::ST_IDLE;
				end
			end
			default: next_state = jdb_pkg::ST_IDLE;
		endcase
	end

	// ----------------------------------------
	// Output decode
	// ----------------------------------------
	// Outputs are decoded from next_state so they turn over on the same edge as the state.
	always_comb begin
		next_drive_mode = jdb_pkg::OUT_OFF;
		next_freq_cmd = `JDB_FREQ_ZERO;
		next_brake_force = 7'h00;
		next_jogging = 1'b0;
		next_config_error = jog_request && !jog_allowed;
		case (next_state)
			jdb_pkg::ST_RUN: begin
				next_drive_mode = jdb_pkg::OUT_RAMP;
				next_freq_cmd = next_saved_freq;
			end
			jdb_pkg::ST_JOG: begin
				next_drive_mode = jdb_pkg::OUT_DIRECT;
				next_freq_cmd = jog_freq;
				next_jogging = 1'b1;
			end
			jdb_pkg::ST_DECEL: begin
				// Deceleration ramps the command down to zero at the drive's own rate.
				next_drive_mode = jdb_pkg::OUT_RAMP;
			end
			jdb_pkg::ST_BRAKE: begin
				next_drive_mode = jdb_pkg::OUT_DC_BRAKE;
				next_brake_force = force_clamped;
			end
			default: begin
				next_drive_mode = jdb_pkg::OUT_OFF;
			end
		endcase
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			state <= jdb_pkg::ST_IDLE;
			run_prev <= 1'b0;
			delay_cnt <= `JDB_DELAY_ZERO;
			saved_freq <= `JDB_FREQ_ZERO;
			jog_stop <= 1'b0;
		end else begin
			state <= next_state;
			run_prev <= run_cmd;
			delay_cnt <= next_delay_cnt;
			saved_freq <= next_saved_freq;
			jog_stop <= next_jog_stop;
		end
	end

	// Command outputs are registered apart from the state so the drive sees glitch-free levels.
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			o_drive_mode <= 2'h0;
			o_freq_cmd <= `JDB_FREQ_ZERO;
			o_brake_force <= 7'h00;
			o_jogging <= 1'b0;
			o_config_error <= 1'b0;
		end else begin
			o_drive_mode <= next_drive_mode;
			o_freq_cmd <= next_freq_cmd;
			o_brake_force <= next_brake_force;
			o_jogging <= next_jogging;
			o_config_error <= next_config_error;
		end
	end
endmodule : jdb_control

// *** rtl/jdb_defines.svh ***
// Constants for the jog and DC-brake input control block.
`ifndef JDB_DEFINES_SVH
`define JDB_DEFINES_SVH
// Frequencies are in units of 0.01 Hz, 16 bits wide.
`define JDB_FREQ_W 16
`define JDB_JOG_CAP_HZ 10
`define JDB_FREQ_SCALE 100
`define JDB_JOG_CAP 16'h03E8
`define JDB_FREQ_ZERO 16'h0000
// Jog mode codes.
`define JDB_MODE_COAST_DIS 3'h0
`define JDB_MODE_DECEL_DIS 3'h1
`define JDB_MODE_BRAKE_DIS 3'h2
`define JDB_MODE_COAST_EN 3'h3
`define JDB_MODE_DECEL_EN 3'h4
`define JDB_MODE_BRAKE_EN 3'h5
`define JDB_MODE_MAX 3'h5
// Terminal function codes.
`define JDB_FUNC_JOG 8'h06
`define JDB_FUNC_BRAKE 8'h07
// Run source code for terminal run.
`define JDB_SRC_TERMINAL 2'h1
// Brake delay in tenths of a second, 0 to 50.
`define JDB_DELAY_MAX 6'h32
`define JDB_DELAY_ZERO 6'h00
`define JDB_FORCE_MAX 7'h64
`define JDB_CLK_HZ 25000000
`define JDB_TENTH_PER_SEC 10
`define JDB_TENTH_CYCLES (`JDB_CLK_HZ / `JDB_TENTH_PER_SEC)
`endif

// *** rtl/jdb_pkg.sv ***
// Types for the jog and DC-brake input control block.
package jdb_pkg;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RUN,
		ST_JOG,
		ST_COAST,
		ST_DECEL,
		ST_BRAKE_WAIT,
		ST_BRAKE,
		ST_LOCKOUT
	} jdb_state_e;
	typedef enum logic [1:0] {
		OUT_OFF,
		OUT_RAMP,
		OUT_DIRECT,
		OUT_DC_BRAKE
	} jdb_drive_e;
endpackage : jdb_pkg

// *** testbench/jdb_control_chk.sv ***
// Assertion checker for the jog and DC-brake control block.
`timescale 1ns/1ps
module jdb_control_chk (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_term_a,
	input wire logic i_term_b,
	input wire logic [7:0] i_term_a_func,
	input wire logic [7:0] i_term_b_func,
	input wire logic [2:0] i_jog_mode_param,
	input wire logic [15:0] i_jog_frequency_param,
	input wire logic [15:0] i_start_frequency_param,
	input wire logic [6:0] i_brake_force_param,
	input wire logic [1:0] o_drive_mode,
	input wire logic [15:0] o_freq_cmd,
	input wire logic [6:0] o_brake_force,
	input wire logic o_jogging,
	input wire logic o_config_error
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);
	logic [15:0] jog_cap;
	logic [6:0] force_cap;
	logic [2:0] mode_rem;
	logic [1:0] end_mode;
	assign jog_cap = (i_jog_frequency_param > 16'h03E8) ? 16'h03E8 : i_jog_frequency_param;
	assign force_cap = (i_brake_force_param > 7'h64) ? 7'h64 : i_brake_force_param;
	assign mode_rem = i_jog_mode_param % 3'h3;
	assign end_mode = (mode_rem == 3'h2) ? 2'h3 : mode_rem[1:0];
	a_jog_cap: assert property (o_jogging |-> o_freq_cmd == jog_cap)
		else $error("jog frequency wrong");
	a_jog_direct: assert property (o_jogging |-> o_drive_mode == 2'h2)
		else $error("jog not direct");
	a_run_entry: assert property ($rose(o_jogging) && $past(o_drive_mode) == 2'h1 |-> i_jog_mode_param >= 3'h3)
		else $error("jog taken during run");
	a_jog_end: assert property ($fell(o_jogging) |-> o_drive_mode == end_mode)
		else $error("jog end method wrong");
	a_jog_legal: assert property (o_jogging |-> i_jog_frequency_param != 16'h0000
		&& i_jog_frequency_param >= i_start_frequency_param && i_jog_mode_param <= 3'h5)
		else $error("jog with bad setting");
	a_cfg_excl: assert property (o_config_error |-> !o_jogging)
		else $error("jog despite refusal");
	a_force_val: assert property (o_drive_mode == 2'h3 |-> o_brake_force == force_cap)
		else $error("brake force wrong");
	a_force_idle: assert property (o_drive_mode != 2'h3 |-> o_brake_force == 7'h00)
		else $error("force outside braking");
	a_jog_term: assert property ($rose(o_jogging) |-> ($past(i_term_a, 2) && i_term_a_func == 8'h06)
		|| ($past(i_term_b, 2) && i_term_b_func == 8'h06))
		else $error("jog without jog terminal");
endmodule : jdb_control_chk
bind jdb_control jdb_control_chk chk (.i_clk, .i_reset, .i_term_a, .i_term_b, .i_term_a_func, .i_term_b_func,
	.i_jog_mode_param, .i_jog_frequency_param, .i_start_frequency_param, .i_brake_force_param,
	.o_drive_mode, .o_freq_cmd, .o_brake_force, .o_jogging, .o_config_error);

// *** testbench/jdb_motor_model.sv ***
// Behavioural motor that reports standstill to the control block.
`timescale 1ns/1ps
module jdb_motor_model #(parameter int STOP_CYC = 6) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic [1:0] i_drive_mode,
	input wire logic [15:0] i_freq_cmd,
	output logic o_motor_stopped
);
	int cnt;
	// The shaft settles only some time after the drive stops pushing it.
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) cnt <= 0;
		else if (i_drive_mode == 2'h2 || (i_drive_mode == 2'h1 && i_freq_cmd != 16'h0000)) cnt <= 0;
		else if (cnt < STOP_CYC) cnt <= cnt + 1;
	end
	assign o_motor_stopped = (cnt == STOP_CYC);
endmodule : jdb_motor_model

// *** testbench/tb_jdb_control.sv ***
// Self-checking testbench for the jog and DC-brake control block.
`timescale 1ns/1ps
module tb_jdb_control;
	logic i_clk, i_reset, term_a, term_b, fw, rv, kp, stopped, jogging, cfg_err;
	logic [1:0] src, drv;
	logic [2:0] mode;
	logic [15:0] jf, sf, setf, freq;
	logic [5:0] dly;
	logic [6:0] frc, bforce;
	logic [7:0] fa, fb;
	int mismatches = 0;
	int cmp_count = 0;
	int cycles = 0;
	jdb_control dut (.i_clk, .i_reset, .i_term_a(term_a), .i_term_b(term_b), .i_forward_run_input(fw),
		.i_reverse_run_input(rv), .i_keypad_run(kp), .i_motor_stopped(stopped), .i_term_a_func(fa),
		.i_term_b_func(fb), .i_run_source_param(src), .i_jog_mode_param(mode), .i_jog_frequency_param(jf),
		.i_start_frequency_param(sf), .i_set_frequency(setf), .i_brake_delay_param(dly),
		.i_brake_force_param(frc), .o_drive_mode(drv), .o_freq_cmd(freq), .o_brake_force(bforce),
		.o_jogging(jogging), .o_config_error(cfg_err));
	jdb_motor_model motor (.i_clk, .i_reset, .i_drive_mode(drv), .i_freq_cmd(freq), .o_motor_stopped(stopped));
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(negedge i_clk);
	endtask : cyc
	task automatic end_sim;
		if (mismatches == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : end_sim
	initial begin
		i_clk = 0;
		forever #20 i_clk = ~i_clk;
	end
	always @(posedge i_clk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			mismatches++;
			end_sim;
		end
	end
	initial begin
		{term_a, term_b, fw, rv, kp} = 5'h00;
		{fa, fb} = {8'h06, 8'h07};
		src = 2'h1;
		mode = 3'h0;
		jf = 16'h07D0;
		sf = 16'h0064;
		setf = 16'h1388;
		dly = 6'h00;
		frc = 7'h32;
		i_reset = 1;
		cyc(8);
		i_reset = 0;
		cyc(2);
		// Jog requested before the run terminal, then released, in every mode.
		for (int m = 0; m < 6; m++) begin
			mode = 3'(m);
			term_a = 1;
			cyc(3);
			if (m[0]) rv = 1;
			else fw = 1;
			cyc(5);
			chk(16'(drv), 16'h0002);
			chk(freq, 16'h03E8);
			chk(16'(jogging), 16'h0001);
			term_a = 0;
			cyc(4);
			chk(16'(drv), (m % 3 == 2) ? 16'h0003 : 16'(m % 3));
			{fw, rv} = 2'h0;
			cyc(30);
		end
		// A jog request during a run counts only in the enabled modes.
		for (int m = 0; m < 6; m += 3) begin
			mode = 3'(m);
			fw = 1;
			cyc(5);
			chk(16'(drv), 16'h0001);
			term_a = 1;
			cyc(5);
			chk(16'(jogging), 16'(m / 3));
			{term_a, fw} = 2'h0;
			cyc(30);
		end
		// Unusable jog settings are refused and the output stays off.
		for (int k = 0; k < 3; k++) begin
			jf = (k == 0) ? 16'h0000 : (k == 1) ? 16'h0032 : 16'h07D0;
			mode = (k == 2) ? 3'h6 : 3'h0;
			term_a = 1;
			cyc(3);
			fw = 1;
			cyc(5);
			chk(16'(drv), 16'h0000);
			chk(16'(cfg_err), 16'h0001);
			{term_a, fw} = 2'h0;
			cyc(30);
		end
		mode = 3'h0;
		// External brake under terminal run, then keypad run with an oversized force.
		for (int k = 0; k < 2; k++) begin
			src = k ? 2'h0 : 2'h1;
			frc = k ? 7'h7F : 7'h32;
			if (k) kp = 1;
			else fw = 1;
			cyc(5);
			chk(16'(drv), 16'h0001);
			term_b = 1;
			cyc(5);
			chk(16'(drv), 16'h0003);
			chk(16'(bforce), k ? 16'h0064 : 16'h0032);
			term_b = 0;
			cyc(5);
			chk(16'(drv), k ? 16'h0000 : 16'h0001);
			if (!k) chk(freq, setf);
			{fw, kp} = 2'h0;
			cyc(30);
		end
		// Terminal functions swapped: term_b now carries the jog request.
		{src, fa, fb} = {2'h1, 8'h07, 8'h06};
		term_b = 1;
		cyc(3);
		fw = 1;
		cyc(5);
		chk(16'(jogging), 16'h0001);
		chk(16'(cfg_err), 16'h0000);
		{term_b, fw} = 2'h0;
		cyc(30);
		{src, fa, fb} = {2'h0, 8'h06, 8'h07};
		// A nonzero delay leaves the motor coasting first; the long wait is not run out.
		dly = 6'h01;
		kp = 1;
		cyc(5);
		term_b = 1;
		cyc(5);
		chk(16'(drv), 16'h0000);
		chk(16'(bforce), 16'h0000);
		{term_b, kp} = 2'h0;
		i_reset = 1;
		cyc(2);
		chk(16'(drv), 16'h0000);
		i_reset = 0;
		cyc(5);
		end_sim;
	end
endmodule : tb_jdb_control
